/* core/ddc_pkg.sv */
// package for the dual-channel output register block
// assumes a register port of address, write data, write and read strobes
package ddc_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CODE0 = 8'h1c;
   localparam logic [7:0] ADDR_CODE1 = 8'h19;
   localparam logic [7:0] ADDR_CONFIG = 8'h1f;
   localparam logic [7:0] ADDR_TRIGGER = 8'h20;
   // ------------------------------------------------------------
   // reset values and fields
   // ------------------------------------------------------------
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h0fff;
   localparam logic [15:0] TRIGGER_RESET = 16'h0000;
   localparam logic [15:0] CODE_MASK = 16'hfff0;
   localparam logic [15:0] CURRENT_MASK = 16'hff00;
   localparam logic [11:0] MID_CODE = 12'h800;
   localparam logic [11:0] ZERO_CODE = 12'h000;
   localparam int CODE_LSB = 4;
   localparam int LOCK_BIT = 14;
   localparam int WINLATCH_BIT = 15;
   localparam int FAULTADDR_BIT = 13;
   localparam int REFEN_BIT = 12;
   localparam int VPD0_LSB = 10;
   localparam int IPD0_BIT = 9;
   localparam int VPD1_LSB = 1;
   localparam int IPD1_BIT = 0;
   localparam int UNLOCK_LSB = 12;
   localparam int RESETF_LSB = 8;
   localparam logic [3:0] UNLOCK_PASSWORD = 4'h5;
   localparam logic [3:0] RESET_KEY = 4'ha;
   localparam int LOAD_BIT = 7;
   localparam int CLEAR_BIT = 6;
   localparam int DUMP_BIT = 4;
   localparam int PROTECT_BIT = 3;
   localparam int ROWREAD_BIT = 2;
   localparam int PROG_BIT = 1;
   localparam int RELOAD_BIT = 0;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ddc_req_type;
   typedef struct packed {
      logic power_on_reset;
      logic sync_load;
      logic output_clear;
      logic fault_dump;
      logic protect;
      logic single_row_read;
      logic nonvolatile_program;
      logic nonvolatile_reload;
   } ddc_pulse_type;
   typedef struct packed {
      logic window_compare_latch_enable;
      logic fault_read_address_select;
      logic internal_reference_enable;
      logic [1:0] voltage_power_down_select0;
      logic current_power_down0;
      logic [1:0] voltage_power_down_select1;
      logic current_power_down1;
   } ddc_cfg_type;
endpackage

/* core/ddc_regs.sv */
// register block: two channel codes, common configuration, triggers
// assumes register requests arrive synchronous to core_clk, one a cycle
`timescale 1ns/1ps
module ddc_regs #(
   parameter int CHANNELS = 2
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire ddc_pkg::ddc_req_type req,
   input wire logic [CHANNELS-1:0] sync_mode,
   input wire logic [CHANNELS-1:0] clear_level_select,
   input wire logic [CHANNELS-1:0] current_output_mode,
   output logic [15:0] rdata,
   output logic rvalid,
   output ddc_pkg::ddc_pulse_type pulses,
   output logic [CHANNELS-1:0] load_strobe,
   output ddc_pkg::ddc_cfg_type cfg,
   output logic [CHANNELS*12-1:0] output_code,
   output logic locked
);
   // ------------------------------------------------------------
   // constants
   // ------------------------------------------------------------
   localparam int CODE_W = $bits(ddc_pkg::ZERO_CODE);
   localparam int NIB_W = $bits(ddc_pkg::UNLOCK_PASSWORD);
   localparam logic [NIB_W-1:0] NIB_ZERO = '0;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [CODE_W-1:0] code_q [CHANNELS];
   logic [CODE_W-1:0] code_d [CHANNELS];
   logic [CODE_W-1:0] out_q [CHANNELS];
   logic [CODE_W-1:0] out_d [CHANNELS];
   logic [15:0] config_q;
   logic [15:0] config_d;
   logic unlock_armed_q;
   logic unlock_armed_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   ddc_pkg::ddc_pulse_type pulses_q;
   ddc_pkg::ddc_pulse_type pulses_d;
   logic [CHANNELS-1:0] load_q;
   logic [CHANNELS-1:0] load_d;

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   logic lock_on;
   logic write_open;
   logic cfg_wr;
   logic trig_wr;
   logic cfg_rd;
   logic password_ok;
   logic reset_key_ok;
   logic lock_release;
   logic [CHANNELS-1:0] code_wr;
   logic [CHANNELS-1:0] code_rd;

   // current mode keeps only the upper eight code bits
   function automatic logic [CODE_W-1:0] code_field(
      input logic [15:0] w,
      input logic cur
   );
      logic [15:0] m;
      m = cur ? ddc_pkg::CURRENT_MASK : ddc_pkg::CODE_MASK;
      code_field = CODE_W'((w & m) >> ddc_pkg::CODE_LSB);
   endfunction

   // register address of one channel code
   function automatic logic [7:0] chan_addr(input int ch);
      chan_addr = (ch == 0) ? ddc_pkg::ADDR_CODE0 : ddc_pkg::ADDR_CODE1;
   endfunction

   // a write strobe aimed at one register address
   function automatic logic hits_write(
      input ddc_pkg::ddc_req_type r,
      input logic [7:0] a
   );
      hits_write = r.wr && (r.addr == a);
   endfunction

   // a read strobe aimed at one register address
   function automatic logic hits_read(
      input ddc_pkg::ddc_req_type r,
      input logic [7:0] a
   );
      hits_read = r.rd && (r.addr == a);
   endfunction

   assign lock_on = config_q[ddc_pkg::LOCK_BIT];
   // locked: only the password and the later lock clear get through
   assign write_open = !lock_on;
   assign cfg_wr = hits_write(req, ddc_pkg::ADDR_CONFIG);
   assign trig_wr = hits_write(req, ddc_pkg::ADDR_TRIGGER);
   assign cfg_rd = hits_read(req, ddc_pkg::ADDR_CONFIG);
   assign password_ok = req.wdata[ddc_pkg::UNLOCK_LSB +: NIB_W] ==
                        ddc_pkg::UNLOCK_PASSWORD;
   assign reset_key_ok = req.wdata[ddc_pkg::RESETF_LSB +: NIB_W] ==
                         ddc_pkg::RESET_KEY;
   assign lock_release = cfg_wr && lock_on && unlock_armed_q &&
                         !req.wdata[ddc_pkg::LOCK_BIT];
   generate
      for (genvar g = 0; g < CHANNELS; g++) begin : g_dec
         assign code_wr[g] = hits_write(req, chan_addr(g));
         assign code_rd[g] = hits_read(req, chan_addr(g));
      end
   endgenerate

   // ------------------------------------------------------------
   // common configuration
   // ------------------------------------------------------------
   always_comb begin
      config_d = config_q;
      if (lock_release) begin
         config_d[ddc_pkg::LOCK_BIT] = 1'h0;
      end
      if (cfg_wr && write_open) begin
         config_d = req.wdata;
      end
      // a software power-on reset restores the whole register
      if (pulses_q.power_on_reset) begin
         config_d = ddc_pkg::CONFIG_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         config_q <= ddc_pkg::CONFIG_RESET;
      end else begin
         config_q <= config_d;
      end
   end

   // ------------------------------------------------------------
   // unlock arming
   // ------------------------------------------------------------
   always_comb begin
      unlock_armed_d = unlock_armed_q;
      if (trig_wr && lock_on && password_ok) begin
         unlock_armed_d = 1'h1;
      end
      // the arm is spent by the lock clear or by any accepted config write
      if (lock_release || (cfg_wr && write_open)) begin
         unlock_armed_d = 1'h0;
      end
      if (pulses_q.power_on_reset) begin
         unlock_armed_d = 1'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         unlock_armed_q <= 1'h0;
      end else begin
         unlock_armed_q <= unlock_armed_d;
      end
   end

   // ------------------------------------------------------------
   // trigger pulses and synchronous load
   // ------------------------------------------------------------
   always_comb begin
      pulses_d = '0;
      load_d = '0;
      if (trig_wr && write_open) begin
         pulses_d.power_on_reset = reset_key_ok;
         pulses_d.sync_load = req.wdata[ddc_pkg::LOAD_BIT];
         pulses_d.output_clear = req.wdata[ddc_pkg::CLEAR_BIT];
         pulses_d.fault_dump = req.wdata[ddc_pkg::DUMP_BIT];
         pulses_d.protect = req.wdata[ddc_pkg::PROTECT_BIT];
         pulses_d.single_row_read = req.wdata[ddc_pkg::ROWREAD_BIT];
         pulses_d.nonvolatile_program = req.wdata[ddc_pkg::PROG_BIT];
         pulses_d.nonvolatile_reload = req.wdata[ddc_pkg::RELOAD_BIT];
         for (int ch = 0; ch < CHANNELS; ch++) begin
            load_d[ch] = req.wdata[ddc_pkg::LOAD_BIT] && sync_mode[ch];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pulses_q <= '0;
         load_q <= '0;
      end else begin
         pulses_q <= pulses_d;
         load_q <= load_d;
      end
   end

   // ------------------------------------------------------------
   // channel codes
   // ------------------------------------------------------------
   always_comb begin
      code_d = code_q;
      for (int ch = 0; ch < CHANNELS; ch++) begin
         if (code_wr[ch] && write_open) begin
            code_d[ch] = code_field(req.wdata, current_output_mode[ch]);
         end
         if (pulses_d.output_clear) begin
            code_d[ch] = clear_level_select[ch] ? ddc_pkg::MID_CODE
                                                : ddc_pkg::ZERO_CODE;
         end
         if (pulses_q.power_on_reset) begin
            code_d[ch] = ddc_pkg::ZERO_CODE;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int ch = 0; ch < CHANNELS; ch++) begin
            code_q[ch] <= ddc_pkg::ZERO_CODE;
         end
      end else begin
         code_q <= code_d;
      end
   end

   // ------------------------------------------------------------
   // active outputs
   // ------------------------------------------------------------
   always_comb begin
      out_d = out_q;
      for (int ch = 0; ch < CHANNELS; ch++) begin
         // async channels follow the code, sync ones wait for the load or an output clear
         if (!sync_mode[ch] || load_d[ch] || pulses_d.output_clear) begin
            out_d[ch] = code_d[ch];
         end
         if (pulses_q.power_on_reset) begin
            out_d[ch] = ddc_pkg::ZERO_CODE;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int ch = 0; ch < CHANNELS; ch++) begin
            out_q[ch] <= ddc_pkg::ZERO_CODE;
         end
      end else begin
         out_q <= out_d;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_comb begin
      rvalid_d = req.rd;
      rdata_d = 16'h0000;
      if (cfg_rd) begin
         rdata_d = config_q;
      end
      for (int ch = 0; ch < CHANNELS; ch++) begin
         if (code_rd[ch]) begin
            rdata_d = {code_q[ch], NIB_ZERO};
         end
      end
      // trigger register reads zero: the read port does not decode its address
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'h0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign pulses = pulses_q;
   assign load_strobe = load_q;
   assign locked = config_q[ddc_pkg::LOCK_BIT];
   assign cfg.window_compare_latch_enable = config_q[ddc_pkg::WINLATCH_BIT];
   assign cfg.fault_read_address_select = config_q[ddc_pkg::FAULTADDR_BIT];
   assign cfg.internal_reference_enable = config_q[ddc_pkg::REFEN_BIT];
   assign cfg.voltage_power_down_select0 = config_q[ddc_pkg::VPD0_LSB +: 2];
   assign cfg.current_power_down0 = config_q[ddc_pkg::IPD0_BIT];
   assign cfg.voltage_power_down_select1 = config_q[ddc_pkg::VPD1_LSB +: 2];
   assign cfg.current_power_down1 = config_q[ddc_pkg::IPD1_BIT];
   generate
      for (genvar g = 0; g < CHANNELS; g++) begin : g_out
         assign output_code[g*12 +: 12] = out_q[g];
      end
   endgenerate
endmodule

/* test/ddc_regs_sva.sv */
// assertion checker for the register block
// assumes ddc_regs ports and ddc_pkg constants
`timescale 1ns/1ps
module ddc_regs_sva #(
   parameter int CHANNELS = 2
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire ddc_pkg::ddc_req_type req,
   input wire logic [15:0] rdata,
   input wire ddc_pkg::ddc_pulse_type pulses,
   input wire ddc_pkg::ddc_cfg_type cfg,
   input wire logic locked
);
   // ------------------------------------------------------------
   // trigger and lock checks
   // ------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic tw;
   assign tw = req.wr && req.addr == ddc_pkg::ADDR_TRIGGER && !locked;
   a_locked_cfg_hold: assert property (
      locked && req.wr |=> $stable(cfg)) else $error("locked cfg moved");
   a_por_pulse: assert property (
      tw && req.wdata[11:8] == 4'ha |=> pulses.power_on_reset)
      else $error("no por pulse");
   a_load_pulse: assert property (
      tw && req.wdata[7] |=> pulses.sync_load) else $error("no load");
   a_clear_pulse: assert property (
      tw && req.wdata[6] |=> pulses.output_clear) else $error("no clear");
   a_dump_pulse: assert property (
      tw && req.wdata[4] |=> pulses.fault_dump) else $error("no dump");
   a_protect_pulse: assert property (
      tw && req.wdata[3] |=> pulses.protect) else $error("no protect");
   a_row_read_pulse: assert property (
      tw && req.wdata[2] |=> pulses.single_row_read) else $error("no row");
   a_reload_pulse: assert property (
      tw && req.wdata[0] |=> pulses.nonvolatile_reload)
      else $error("no reload");
   a_trigger_reads_zero: assert property (
      req.rd && req.addr == ddc_pkg::ADDR_TRIGGER |=> rdata == 16'h0000)
      else $error("trigger read not zero");
   a_prog_pulse: assert property (
      tw && req.wdata[1] |=> pulses.nonvolatile_program)
      else $error("no program pulse");
   a_no_stray_pulse: assert property (
      !tw |=> pulses == '0) else $error("stray trigger pulse");
endmodule
bind ddc_regs ddc_regs_sva #(.CHANNELS(CHANNELS)) u_ddc_regs_sva (
   .core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata),
   .pulses(pulses), .cfg(cfg), .locked(locked));

/* test/testbench.sv */
// self-checking bench for the register block
// assumes ddc_regs and ddc_pkg compiled first
`timescale 1ns/1ps
module testbench;
   // ------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   ddc_pkg::ddc_req_type req = '0;
   logic [1:0] sync_mode = 2'h1;
   logic [1:0] clr_sel = 2'h1;
   logic [1:0] cur_mode = 2'h2;
   logic [15:0] rdata;
   logic rvalid;
   ddc_pkg::ddc_pulse_type pulses;
   logic [1:0] ls;
   ddc_pkg::ddc_cfg_type cfg;
   logic [23:0] oc;
   logic locked;
   int mismatches = 0;
   int cmp_count = 0;
   logic [15:0] tv [7] = '{16'h0080, 16'h0040, 16'h0010, 16'h0008,
      16'h0004, 16'h0002, 16'h0001};
   logic [7:0] pv [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
   always #5 core_clk = ~core_clk;
   ddc_regs u_ddc_regs (.core_clk(core_clk), .reset(reset), .req(req),
      .sync_mode(sync_mode), .clear_level_select(clr_sel),
      .current_output_mode(cur_mode), .rdata(rdata), .rvalid(rvalid),
      .pulses(pulses), .load_strobe(ls), .cfg(cfg), .output_code(oc),
      .locked(locked));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk(input logic [23:0] g, input logic [23:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge core_clk);
      req.wr <= 1'b0;
      #1;
   endtask
   task rreg(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      chk(24'(rvalid), 24'h1);
      chk(24'(rdata), 24'(e));
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #20000;
      mismatches++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      rreg(8'h1f, 16'h0fff);
      rreg(8'h1c, 16'h0000);
      rreg(8'h19, 16'h0000);
      rreg(8'h00, 16'h0000);
      $display("reset values done");
      wreg(8'h1c, 16'habcf);
      chk(24'(oc[11:0]), 24'h000);
      rreg(8'h1c, 16'habc0);
      wreg(8'h19, 16'h1234);
      chk(24'(oc[23:12]), 24'h120);
      for (int c = 0; c < 4; c++) begin
         wreg(8'h1f, {c[1], 1'b0, c[0], 1'b1, c[1:0], 1'b0, 6'h00,
            c[1:0], 1'b0});
         chk(24'(cfg), 24'({c[1], c[0], 1'b1, c[1:0], 1'b0, c[1:0],
            1'b0}));
      end
      $display("config done");
      for (int i = 0; i < 7; i++) begin
         wreg(8'h20, tv[i]);
         chk(24'(pulses), 24'(pv[i]));
         chk(24'(ls), (i == 0) ? 24'h1 : 24'h0);
         if (i == 0) chk(24'(oc[11:0]), 24'habc);
      end
      chk(oc, 24'h000800);
      rreg(8'h20, 16'h0000);
      wreg(8'h20, 16'h0500);
      chk(24'(pulses), 24'h0);
      $display("triggers done");
      wreg(8'h1f, 16'h4fff);
      chk(24'(locked), 24'h1);
      wreg(8'h1c, 16'h1110);
      rreg(8'h1c, 16'h8000);
      wreg(8'h20, 16'h0040);
      chk(24'(pulses), 24'h0);
      wreg(8'h20, 16'h3000);
      wreg(8'h1f, 16'h0000);
      chk(24'(locked), 24'h1);
      wreg(8'h20, 16'h5000);
      chk(24'(pulses), 24'h0);
      wreg(8'h1f, 16'h0000);
      chk(24'(locked), 24'h0);
      chk(24'(cfg), 24'h03f);
      $display("lock done");
      wreg(8'h1f, 16'h3000);
      wreg(8'h20, 16'h0a00);
      chk(24'(pulses), 24'h80);
      rreg(8'h1f, 16'h0fff);
      rreg(8'h1c, 16'h0000);
      $display("power-on reset done");
      close_out;
   end
endmodule
